/* src/tlic_ctrl.sv */
`timescale 1ns/10ps
// Behaviour
// - enabled pending event vectors core to 0x0004
// - both per-event and global enable required
// - enable bit 1 allows, 0 blocks event
// - global enable is bit 7 of enable 1
// - vector entry clears global enable
// - interrupt return sets global enable again
// - subroutine return leaves global enable unchanged
// - enable 1 at 0x23, reset zero
// - enable 2 at 0x24, bits 5:4 absent
// - enable 3 at 0x25, pins 7..2
// - flags 1 at 0x26, bit 7 absent
// - flags 2 at 0x27, bits 5:4 absent
// - flags 3 at 0x28, pins 7..2
// - flag reads 1 once its event happened
module tlic_ctrl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // data-memory register port from the core
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // core instruction events
  input wire logic vector_taken_i,
  input wire logic interrupt_return_instr_i,
  input wire logic subroutine_return_instr_i,
  // vector request to the core
  output logic irq_req_o,
  output logic [13:0] irq_vector_o,
  // event sources, same-clock pulses or levels
  input wire logic [23:0] evt_sync_i,
  // event sources, asynchronous pins
  input wire logic [7:0] pin_evt_i,
  // global enable state
  output logic global_irq_enable_o
);

  typedef struct packed {
    logic [23:0] enable;
    logic [23:0] flags;
    logic [23:0] pin_prev;
    logic [7:0] rdata;
    logic hit;
    logic req;
    logic [13:0] vector;
  } tlic_state_t;

  function automatic logic [1:0] reg_index(input logic [7:0] addr);
    logic [1:0] idx;
    idx = 2'h3;
    unique case (addr)
      tlic_pkg::ADDR_IRQ_ENABLE_1, tlic_pkg::ADDR_IRQ_FLAGS_1: idx = 2'h0;
      tlic_pkg::ADDR_IRQ_ENABLE_2, tlic_pkg::ADDR_IRQ_FLAGS_2: idx = 2'h1;
      tlic_pkg::ADDR_IRQ_ENABLE_3, tlic_pkg::ADDR_IRQ_FLAGS_3: idx = 2'h2;
      default: idx = 2'h3;
    endcase
    return idx;
  endfunction : reg_index

  function automatic logic is_flag_reg(input logic [7:0] addr);
    return (addr == tlic_pkg::ADDR_IRQ_FLAGS_1) || (addr == tlic_pkg::ADDR_IRQ_FLAGS_2) ||
           (addr == tlic_pkg::ADDR_IRQ_FLAGS_3);
  endfunction : is_flag_reg

  tlic_state_t st_q;
  tlic_state_t st_d;
  logic [23:0] pin_sync;
  logic [23:0] pin_wide;
  logic [23:0] events;
  logic [23:0] wr_mask;
  logic [23:0] wr_val;
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic gie_next;

  // pins 0,1 live in register 1, pins 2..7 in register 3
  tlic_sync #(
    .WIDTH(24)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .async_i(pin_wide),
    .sync_o(pin_sync)
  );

  always_comb begin
    pin_wide = '0;
    pin_wide[tlic_pkg::EVT_PIN0] = pin_evt_i[0];
    pin_wide[tlic_pkg::EVT_PIN1] = pin_evt_i[1];
    pin_wide[tlic_pkg::EVT_PIN7:tlic_pkg::EVT_PIN2] = pin_evt_i[7:2];
  end

  always_comb begin
    st_d = st_q;
    wr_idx = reg_index(reg_addr_i);
    rd_idx = reg_index(reg_addr_i);
    wr_mask = '0;
    wr_val = {3{reg_wdata_i}};
    unique case (wr_idx)
      2'h0: wr_mask = 24'h0000ff;
      2'h1: wr_mask = 24'h00ff00;
      2'h2: wr_mask = 24'hff0000;
      default: wr_mask = '0;
    endcase
    wr_mask = wr_mask & tlic_pkg::EVT_MASK;

    // pin events are rising edges of synchronised pins; other sources are pulses
    st_d.pin_prev = pin_sync;
    events = ((pin_sync & ~st_q.pin_prev) | evt_sync_i) & tlic_pkg::EVT_MASK;

    // per-event enables and global enable
    if (reg_wr_i && !is_flag_reg(reg_addr_i)) begin
      st_d.enable = (st_q.enable & ~wr_mask) | (wr_val & wr_mask);
    end
    gie_next = (reg_wr_i && reg_addr_i == tlic_pkg::ADDR_IRQ_ENABLE_1) ?
               reg_wdata_i[tlic_pkg::GIE_BIT] : st_q.enable[tlic_pkg::GIE_BIT];
    // hardware actions override a software write in the same cycle
    if (vector_taken_i) begin
      gie_next = 1'b0;
    end else if (interrupt_return_instr_i) begin
      gie_next = 1'b1;
    end
    // subroutine return takes no part in global enable
    st_d.enable[tlic_pkg::GIE_BIT] = gie_next;

    // flags: software writes, set wins over clear in the same cycle
    if (reg_wr_i && is_flag_reg(reg_addr_i)) begin
      st_d.flags = (st_q.flags & ~wr_mask) | (wr_val & wr_mask);
    end
    st_d.flags = st_d.flags | events;

    // two-level gating; gie bit itself is no event
    st_d.req = gie_next && |(st_d.flags & st_d.enable & tlic_pkg::EVT_MASK);
    st_d.vector = tlic_pkg::IRQ_VECTOR_ADDR;

    // registered read port, one cycle after the request
    st_d.hit = (reg_rd_i || reg_wr_i) && (rd_idx != 2'h3);
    st_d.rdata = '0;
    if (reg_rd_i) begin
      unique case (rd_idx)
        2'h0: st_d.rdata = is_flag_reg(reg_addr_i) ? st_q.flags[7:0] : st_q.enable[7:0];
        2'h1: st_d.rdata = is_flag_reg(reg_addr_i) ? st_q.flags[15:8] : st_q.enable[15:8];
        2'h2: st_d.rdata = is_flag_reg(reg_addr_i) ? st_q.flags[23:16] : st_q.enable[23:16];
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_o = st_q.rdata;
  assign reg_hit_o = st_q.hit;
  assign irq_req_o = st_q.req;
  assign irq_vector_o = st_q.vector;
  assign global_irq_enable_o = st_q.enable[tlic_pkg::GIE_BIT];

endmodule : tlic_ctrl

/* src/tlic_pkg.sv */
package tlic_pkg;

  // data-memory addresses
  localparam logic [7:0] ADDR_IRQ_ENABLE_1 = 8'h23;
  localparam logic [7:0] ADDR_IRQ_ENABLE_2 = 8'h24;
  localparam logic [7:0] ADDR_IRQ_ENABLE_3 = 8'h25;
  localparam logic [7:0] ADDR_IRQ_FLAGS_1 = 8'h26;
  localparam logic [7:0] ADDR_IRQ_FLAGS_2 = 8'h27;
  localparam logic [7:0] ADDR_IRQ_FLAGS_3 = 8'h28;

  // implemented-bit masks; unimplemented bits read as zero
  localparam logic [7:0] MASK_ENABLE_1 = 8'hff;
  localparam logic [7:0] MASK_ENABLE_2 = 8'hcf;
  localparam logic [7:0] MASK_ENABLE_3 = 8'hfc;
  localparam logic [7:0] MASK_FLAGS_1 = 8'h7f;
  localparam logic [7:0] MASK_FLAGS_2 = 8'hcf;
  localparam logic [7:0] MASK_FLAGS_3 = 8'hfc;

  localparam logic [7:0] RESET_REG = 8'h00;
  localparam int GIE_BIT = 7;
  localparam logic [13:0] IRQ_VECTOR_ADDR = 14'h0004;

  // event source positions in the 24-bit event vector (reg1 bits 0..7, reg2 8..15, reg3 16..23)
  localparam int EVT_PIN0 = 0;
  localparam int EVT_PIN1 = 1;
  localparam int EVT_WATCHDOG = 2;
  localparam int EVT_TIMER_A = 3;
  localparam int EVT_TIMER_B = 4;
  localparam int EVT_TIMER_C = 5;
  localparam int EVT_ADC = 6;
  localparam int EVT_CAPCMP0 = 8;
  localparam int EVT_CAPCMP1 = 9;
  localparam int EVT_SPI = 10;
  localparam int EVT_COMPARATOR = 11;
  localparam int EVT_UART_RX = 14;
  localparam int EVT_UART_TX = 15;
  localparam int EVT_PIN2 = 18;
  localparam int EVT_PIN7 = 23;
  localparam int NUM_EVT_BITS = 24;
  localparam logic [23:0] EVT_MASK = {MASK_FLAGS_3, MASK_FLAGS_2, MASK_FLAGS_1};

  // core-side bus access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlic_bus_t;

  // core instruction events
  typedef struct packed {
    logic vector_taken;
    logic interrupt_return_instr;
    logic subroutine_return_instr;
  } tlic_core_evt_t;

endpackage : tlic_pkg

/* src/tlic_sync.sv */
`timescale 1ns/10ps
// two-flop synchroniser for asynchronous event sources
module tlic_sync #(
  parameter int WIDTH = 24
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } tlic_sync_st_t;

  tlic_sync_st_t st_q;
  tlic_sync_st_t st_d;

  always_comb begin
    st_d.meta = async_i;
    st_d.sync = st_q.meta;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.sync;

endmodule : tlic_sync

/* tb/tlic_chk.sv */
`timescale 1ns/10ps
module tlic_chk (
  // register port
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  // core side
  input wire logic vector_taken_i,
  input wire logic interrupt_return_instr_i,
  input wire logic subroutine_return_instr_i,
  input wire logic irq_req_o,
  input wire logic [13:0] irq_vector_o,
  input wire logic global_irq_enable_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_enter;
    irq_req_o ##1 vector_taken_i;
  endsequence
  vec_addr_a: assert property (irq_req_o |-> irq_vector_o == 14'h0004) else $error("vector");
  req_gated_a: assert property (irq_req_o |-> global_irq_enable_o) else $error("req");
  entry_clear_a: assert property (s_enter |=> !global_irq_enable_o && !irq_req_o)
    else $error("entry");
  return_set_a: assert property (interrupt_return_instr_i && !vector_taken_i |=> global_irq_enable_o)
    else $error("return");
  plain_ret_a: assert property (subroutine_return_instr_i && !global_irq_enable_o && !reg_wr_i
    && !interrupt_return_instr_i |=> !global_irq_enable_o) else $error("plain");
  gie_write_a: assert property (reg_wr_i && reg_addr_i == 8'h23 && !vector_taken_i
    && !interrupt_return_instr_i |=> global_irq_enable_o == $past(reg_wdata_i[7])) else $error("gie");
  reg_hit_a: assert property (reg_rd_i || reg_wr_i |=> reg_hit_o == ($past(reg_addr_i) inside {[8'h23:8'h28]}))
    else $error("hit");
  flag_top_a: assert property (reg_rd_i && reg_addr_i == 8'h26 |=> !reg_rdata_o[7]) else $error("flag");
endmodule : tlic_chk
bind tlic_ctrl tlic_chk u_chk (.clk_sys_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .reg_rdata_o, .reg_hit_o, .vector_taken_i, .interrupt_return_instr_i, .subroutine_return_instr_i,
  .irq_req_o, .irq_vector_o, .global_irq_enable_o);

/* tb/tlic_core_model.sv */
`timescale 1ns/10ps
module tlic_core_model (
  // core: enters the vector delay_i + 1 cycles after a request
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic irq_req_i,
  input wire logic [3:0] delay_i,
  output logic vector_taken_o
);
  logic [3:0] w_q;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      w_q <= 4'h0;
      vector_taken_o <= 1'b0;
    end else begin
      vector_taken_o <= irq_req_i && !vector_taken_o && w_q == delay_i;
      w_q <= (irq_req_i && w_q != delay_i) ? w_q + 4'h1 : 4'h0;
    end
  end
endmodule : tlic_core_model

/* tb/test_two_level_interrupt_controller.sv */
`timescale 1ns/10ps
module test_two_level_interrupt_controller;
  logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, vec, req, global_irq_enable, hit;
  logic [1:0] ret = 2'b00;
  logic [7:0] a = 8'h00, wd = 8'h00, pins = 8'h00, rdat;
  logic [23:0] ev = 24'h0;
  logic [13:0] vaddr;
  logic [7:0] msk [3] = '{8'hff, 8'hcf, 8'hfc};
  int n_fail = 0, checked = 0;
  tlic_ctrl DUT (.clk_sys_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(a), .reg_wdata_i(wd),
    .reg_rdata_o(rdat), .reg_hit_o(hit), .vector_taken_i(vec), .interrupt_return_instr_i(ret[1]),
    .subroutine_return_instr_i(ret[0]), .irq_req_o(req), .irq_vector_o(vaddr), .evt_sync_i(ev), .pin_evt_i(pins),
    .global_irq_enable_o(global_irq_enable));
  tlic_core_model u_core (.clk_sys_i(clk), .rst_b_i(rst_b), .irq_req_i(req), .delay_i(4'h3), .vector_taken_o(vec));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task chk(input string nm, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // read result packs {req, hit, data}
  task acc(input logic w, input logic [7:0] ad, d, input logic [15:0] e);
    wr <= w;
    rd <= !w;
    a <= ad;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    if (!w)
      chk($sformatf("reg %h", ad), {6'h0, req, hit, rdat}, e);
    @(posedge clk);
  endtask : acc
  task end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim
  initial begin
    #50us;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      acc(1'b0, 8'(8'h23 + i), 8'h00, 16'h0100);
      if (i < 3) begin
        acc(1'b1, 8'(8'h23 + i), 8'hff, 16'h0);
        acc(1'b0, 8'(8'h23 + i), 8'h00, {8'h01, msk[i]});
        acc(1'b1, 8'(8'h23 + i), 8'h00, 16'h0);
      end
    end
    acc(1'b0, 8'h29, 8'h00, 16'h0);
    ev <= 24'h000040;
    @(posedge clk);
    ev <= 24'h0;
    acc(1'b0, 8'h26, 8'h00, 16'h0140);
    acc(1'b1, 8'h23, 8'h40, 16'h0);
    acc(1'b0, 8'h23, 8'h00, 16'h0140);
    acc(1'b1, 8'h25, 8'h80, 16'h0);
    acc(1'b1, 8'h23, 8'h80, 16'h0);
    acc(1'b0, 8'h23, 8'h00, 16'h0180);
    pins <= 8'h80;
    for (int k = 0; k < 20 && global_irq_enable !== 1'b0; k++)
      @(posedge clk);
    acc(1'b0, 8'h28, 8'h00, 16'h0180);
    acc(1'b0, 8'h23, 8'h00, 16'h0100);
    acc(1'b1, 8'h28, 8'h00, 16'h0);
    ret <= 2'b01;
    @(posedge clk);
    ret <= 2'b10;
    @(posedge clk);
    ret <= 2'b00;
    acc(1'b0, 8'h23, 8'h00, 16'h0180);
    // adc flag still pending: enabling it with gie raises the request
    acc(1'b1, 8'h23, 8'hc0, 16'h0);
    acc(1'b0, 8'h23, 8'h00, 16'h03c0);
    chk("vector", {2'h0, vaddr}, 16'h0004);
    // core model vectors a few cycles later and clears gie
    repeat (4) @(posedge clk);
    ret <= 2'b01;
    @(posedge clk);
    ret <= 2'b00;
    acc(1'b0, 8'h23, 8'h00, 16'h0140);
    end_sim();
  end
endmodule : test_two_level_interrupt_controller
